// >>> rtl/drive_frequency_sequencer_defines.svh
`ifndef DRIVE_FREQUENCY_SEQUENCER_DEFINES_SVH
`define DRIVE_FREQUENCY_SEQUENCER_DEFINES_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_UPPER       8'h04
`define OFS_LOWER       8'h08
`define OFS_GAIN        8'h0C
`define OFS_BIAS        8'h10
`define OFS_MAXFREQ     8'h14
`define OFS_DCB_FREQ    8'h18
`define OFS_DCB_LEVEL   8'h1C
`define OFS_DCB_TIME    8'h20
`define OFS_START_FREQ  8'h24
`define OFS_HOLD_TIME   8'h28
`define OFS_STOP_FREQ   8'h2C
`define OFS_CARRIER     8'h30
`define OFS_STATUS      8'h34
`define OFS_OUT_FREQ    8'h38
`define OFS_COMMAND     8'h3C

// reset values (frequency in 0.1 Hz, time in 0.1 s, carrier in 10 Hz)
`define RST_UPPER       16'h0FA0
`define RST_LOWER       16'h0000
`define RST_GAIN        16'h01F4
`define RST_BIAS        16'h0000
`define RST_MAXFREQ     16'h01F4
`define RST_DCB_FREQ    16'h0000
`define RST_DCB_LEVEL   7'h00
`define RST_DCB_TIME    9'h000
`define RST_START_FREQ  16'h0005
`define RST_HOLD_TIME   7'h00
`define RST_STOP_FREQ   16'h0002
`define RST_CARRIER     11'h0320

// fixed figures
`define PICKUP_MIN      16'h0032
`define PICKUP_MAX      16'h04B0
`define DCB_FLOOR       7'h05
`define CARRIER_MIN     11'h04B
`define CARRIER_MAX     11'h5DC
`define TONE_CARRIER    11'h2BC

// timing: 0.1 s time unit and a ramp step interval
`define CLK_PERIOD_NS   10
`define TIME_UNIT_NS    100000000
`define TICK_CYCLES     (`TIME_UNIT_NS / `CLK_PERIOD_NS)
`define RAMP_STEP_NS    100000
`define RAMP_CYCLES     (`RAMP_STEP_NS / `CLK_PERIOD_NS)

`endif

// >>> rtl/drive_frequency_sequencer_pkg.sv
package drive_frequency_sequencer_pkg;

	typedef enum logic [5:0]
	{
		ST_IDLE    = 6'h01,
		ST_HOLD    = 6'h02,
		ST_RUN     = 6'h04,
		ST_BRAKE   = 6'h08,
		ST_PWRLOSS = 6'h10,
		ST_TRIPPED = 6'h20
	} seq_state_t;

	typedef struct packed
	{
		logic       monitor_output_select;
		logic [1:0] sound_tone_select;
		logic       speed_pickup_select;
		logic [1:0] power_loss_restart_select;
	} ctrl_t;

	typedef struct packed
	{
		logic [15:0] freq;
		logic        enable;
		logic        reverse;
	} drive_out_t;

	typedef struct packed
	{
		logic       active;
		logic [6:0] level;
	} brake_out_t;

endpackage : drive_frequency_sequencer_pkg

// >>> rtl/drive_frequency_sequencer.sv
`include "drive_frequency_sequencer_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module drive_frequency_sequencer #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
	parameter int unsigned RAMP_CYCLES = `RAMP_CYCLES,
	parameter bit          LARGE_MODEL = 1'b0
) (
	// clock and reset
	input  wire logic                               mclk,
	input  wire logic                               rst,
	// register port
	input  wire logic [7:0]                         addr,
	input  wire logic [31:0]                        wr_data,
	input  wire logic                               wr_strobe,
	input  wire logic                               rd_strobe,
	output logic [31:0]                             rd_data,
	// pins and measurements
	input  wire logic                               run_fwd,
	input  wire logic                               run_rev,
	input  wire logic                               undervoltage,
	input  wire logic [11:0]                        analog_in,
	input  wire logic                               pickup_valid,
	input  wire logic [15:0]                        pickup_freq,
	// drive outputs
	output drive_frequency_sequencer_pkg::drive_out_t drive_out,
	output drive_frequency_sequencer_pkg::brake_out_t brake_out,
	output logic                                    trip,
	output logic [10:0]                             carrier_freq,
	output logic [1:0]                              tone_pattern,
	output logic                                    monitor_analog_output,
	output logic                                    monitor_pulse_output
);

	drive_frequency_sequencer_pkg::seq_state_t state_reg, state_next;
	drive_frequency_sequencer_pkg::ctrl_t      ctrl_reg;

	logic [15:0] freq_upper_limit_reg, freq_lower_limit_reg;
	logic [15:0] analog_freq_gain_reg, max_freq_reg;
	logic [15:0] bias_frequency_reg;
	logic [15:0] dc_brake_start_freq_reg, starting_freq_reg;
	logic [15:0] stopping_freq_reg;
	logic [6:0]  dc_brake_level_reg, starting_hold_time_reg;
	logic [8:0]  dc_brake_time_reg;
	logic [10:0] carrier_freq_setting_reg;
	logic [15:0] out_freq_reg, out_freq_next, latched_freq_reg;
	logic        trip_reg, trip_next, dir_reg, dir_next;
	logic        skip_hold_reg, skip_hold_next, refused_reg;
	logic [8:0]  sec_cnt_reg, sec_cnt_next;
	logic [31:0] tick_cnt_reg, ramp_cnt_reg;
	logic [31:0] rd_data_reg;
	logic [2:0]  sync1_reg, sync2_reg;

	// pin synchronisers
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge mclk or posedge rst)
			begin
				if (rst)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end
				else
				begin
					sync1_reg[gi] <= (gi == 0) ? run_fwd :
						(gi == 1) ? run_rev : undervoltage;
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	wire logic uv_s    = sync2_reg[2];
	wire logic run_cmd = sync2_reg[0] ^ sync2_reg[1];
	wire logic dir_cmd = sync2_reg[1];

	// setpoint: gain and bias first, limiter after
	wire logic [27:0] scaled_prod = analog_in * analog_freq_gain_reg;
	wire logic signed [16:0] bias_s   = $signed({bias_frequency_reg[15],
		bias_frequency_reg});
	wire logic signed [16:0] max_pos  = $signed({1'b0, max_freq_reg});
	wire logic signed [16:0] bias_c   = (bias_s > max_pos) ? max_pos :
		(bias_s < -max_pos) ? -max_pos : bias_s;
	wire logic signed [17:0] sum_s    = $signed({2'b00, scaled_prod[27:12]})
		+ $signed({bias_c[16], bias_c});
	wire logic [15:0] sp_raw = sum_s[17] ? 16'h0000 :
		(sum_s[16] ? 16'hFFFF : sum_s[15:0]);
	wire logic [15:0] eff_low = (freq_lower_limit_reg > freq_upper_limit_reg)
		? freq_upper_limit_reg : freq_lower_limit_reg;
	wire logic [15:0] target = (sp_raw > freq_upper_limit_reg)
		? freq_upper_limit_reg
		: (sp_raw < eff_low) ? eff_low : sp_raw;

	// start refusal and restart source
	wire logic start_refused = (starting_freq_reg < stopping_freq_reg) &&
		(target < stopping_freq_reg);
	wire logic pickup_ok = ctrl_reg.speed_pickup_select && pickup_valid &&
		(pickup_freq >= `PICKUP_MIN) && (pickup_freq <= `PICKUP_MAX);
	wire logic [1:0] rmode = ctrl_reg.power_loss_restart_select;
	wire logic [15:0] resume_freq = pickup_ok ? pickup_freq :
		(rmode == 2'h2) ? latched_freq_reg : starting_freq_reg;
	wire logic running = (state_reg == drive_frequency_sequencer_pkg::ST_HOLD)
		|| (state_reg == drive_frequency_sequencer_pkg::ST_RUN)
		|| (state_reg == drive_frequency_sequencer_pkg::ST_BRAKE);
	wire logic stopping = !run_cmd || (dir_cmd != dir_reg);
	wire logic tick = (tick_cnt_reg == TICK_CYCLES - 1);
	wire logic ramp_step = (ramp_cnt_reg == RAMP_CYCLES - 1);
	wire logic [6:0] brake_level = (LARGE_MODEL &&
		(dc_brake_level_reg != 7'h00) && (dc_brake_level_reg < `DCB_FLOOR))
		? `DCB_FLOOR : dc_brake_level_reg;
	wire logic [15:0] ramp_up = out_freq_reg + 16'h0001;
	wire logic [15:0] ramp_dn = out_freq_reg - 16'h0001;

	// sequencer
	always_comb
	begin
		state_next     = state_reg;
		out_freq_next  = out_freq_reg;
		trip_next      = trip_reg;
		dir_next       = dir_reg;
		skip_hold_next = skip_hold_reg;
		sec_cnt_next   = tick ? sec_cnt_reg + 9'h001 : sec_cnt_reg;
		unique case (state_reg)
			drive_frequency_sequencer_pkg::ST_IDLE:
			begin
				out_freq_next = 16'h0000;
				sec_cnt_next  = 9'h000;
				if (run_cmd && !start_refused && !uv_s)
				begin
					dir_next      = dir_cmd;
					out_freq_next = starting_freq_reg;
					state_next    = skip_hold_reg
						? drive_frequency_sequencer_pkg::ST_RUN
						: drive_frequency_sequencer_pkg::ST_HOLD;
					skip_hold_next = 1'b0;
				end
			end
			drive_frequency_sequencer_pkg::ST_HOLD:
			begin
				if (sec_cnt_reg >= {2'b00, starting_hold_time_reg})
					state_next = drive_frequency_sequencer_pkg::ST_RUN;
			end
			drive_frequency_sequencer_pkg::ST_RUN:
			begin
				sec_cnt_next = 9'h000;
				if (stopping)
				begin
					if (dc_brake_time_reg != 9'h000 &&
						out_freq_reg <= dc_brake_start_freq_reg)
					begin
						out_freq_next = 16'h0000;
						state_next    = drive_frequency_sequencer_pkg::ST_BRAKE;
					end
					else if (out_freq_reg <= stopping_freq_reg)
					begin
						out_freq_next = 16'h0000;
						state_next    = drive_frequency_sequencer_pkg::ST_IDLE;
					end
					else if (ramp_step)
						out_freq_next = ramp_dn;
					skip_hold_next = run_cmd;
				end
				else if (ramp_step && out_freq_reg < target)
					out_freq_next = ramp_up;
				else if (ramp_step && out_freq_reg > target)
					out_freq_next = ramp_dn;
			end
			drive_frequency_sequencer_pkg::ST_BRAKE:
			begin
				out_freq_next = 16'h0000;
				if (sec_cnt_reg >= dc_brake_time_reg)
					state_next = drive_frequency_sequencer_pkg::ST_IDLE;
			end
			drive_frequency_sequencer_pkg::ST_PWRLOSS:
			begin
				out_freq_next = 16'h0000;
				if (!uv_s)
				begin
					if (rmode == 2'h1)
					begin
						trip_next  = 1'b1;
						state_next = drive_frequency_sequencer_pkg::ST_TRIPPED;
					end
					else if (run_cmd)
					begin
						out_freq_next = resume_freq;
						state_next    = drive_frequency_sequencer_pkg::ST_RUN;
					end
					else
						state_next = drive_frequency_sequencer_pkg::ST_IDLE;
				end
			end
			drive_frequency_sequencer_pkg::ST_TRIPPED:
			begin
				out_freq_next = 16'h0000;
				if (wr_strobe && addr == `OFS_COMMAND && wr_data[0])
				begin
					trip_next  = 1'b0;
					state_next = drive_frequency_sequencer_pkg::ST_IDLE;
				end
			end
			default:
			begin
				out_freq_next = 16'h0000;
				state_next    = drive_frequency_sequencer_pkg::ST_IDLE;
			end
		endcase
		if (running && uv_s)
		begin
			out_freq_next = 16'h0000;
			if (rmode == 2'h0)
			begin
				trip_next  = 1'b1;
				state_next = drive_frequency_sequencer_pkg::ST_TRIPPED;
			end
			else
				state_next = drive_frequency_sequencer_pkg::ST_PWRLOSS;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_reg     <= drive_frequency_sequencer_pkg::ST_IDLE;
			out_freq_reg  <= 16'h0000;
			trip_reg      <= 1'b0;
			dir_reg       <= 1'b0;
			skip_hold_reg <= 1'b0;
			sec_cnt_reg   <= 9'h000;
		end
		else
		begin
			state_reg     <= state_next;
			out_freq_reg  <= out_freq_next;
			trip_reg      <= trip_next;
			dir_reg       <= dir_next;
			skip_hold_reg <= skip_hold_next;
			sec_cnt_reg   <= sec_cnt_next;
		end
	end

	// latch frequency at power loss; time bases
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			latched_freq_reg <= 16'h0000;
			tick_cnt_reg     <= 32'h0000_0000;
			ramp_cnt_reg     <= 32'h0000_0000;
			refused_reg      <= 1'b0;
		end
		else
		begin
			if (running && uv_s)
				latched_freq_reg <= out_freq_reg;
			tick_cnt_reg <= (tick || !running || state_reg ==
				drive_frequency_sequencer_pkg::ST_RUN) ? 32'h0000_0000
				: tick_cnt_reg + 32'h0000_0001;
			ramp_cnt_reg <= ramp_step ? 32'h0000_0000
				: ramp_cnt_reg + 32'h0000_0001;
			refused_reg  <= (state_reg == drive_frequency_sequencer_pkg::ST_IDLE)
				&& run_cmd && start_refused;
		end
	end

	// register writes
	wire logic wr_hit = wr_strobe;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg                 <= '0;
			freq_upper_limit_reg     <= `RST_UPPER;
			freq_lower_limit_reg     <= `RST_LOWER;
			analog_freq_gain_reg     <= `RST_GAIN;
			bias_frequency_reg       <= `RST_BIAS;
			max_freq_reg             <= `RST_MAXFREQ;
			dc_brake_start_freq_reg  <= `RST_DCB_FREQ;
			dc_brake_level_reg       <= `RST_DCB_LEVEL;
			dc_brake_time_reg        <= `RST_DCB_TIME;
			starting_freq_reg        <= `RST_START_FREQ;
			starting_hold_time_reg   <= `RST_HOLD_TIME;
			stopping_freq_reg        <= `RST_STOP_FREQ;
			carrier_freq_setting_reg <= `RST_CARRIER;
		end
		else if (wr_hit)
		begin
			unique case (addr)
				`OFS_CTRL:       ctrl_reg <= wr_data[5:0];
				`OFS_UPPER:      freq_upper_limit_reg <= wr_data[15:0];
				`OFS_LOWER:      freq_lower_limit_reg <= wr_data[15:0];
				`OFS_GAIN:       analog_freq_gain_reg <= wr_data[15:0];
				`OFS_BIAS:       bias_frequency_reg <= wr_data[15:0];
				`OFS_MAXFREQ:    max_freq_reg <= wr_data[15:0];
				`OFS_DCB_FREQ:   dc_brake_start_freq_reg <= wr_data[15:0];
				`OFS_DCB_LEVEL:  dc_brake_level_reg <= wr_data[6:0];
				`OFS_DCB_TIME:   dc_brake_time_reg <= wr_data[8:0];
				`OFS_START_FREQ: starting_freq_reg <= wr_data[15:0];
				`OFS_HOLD_TIME:  starting_hold_time_reg <= wr_data[6:0];
				`OFS_STOP_FREQ:  stopping_freq_reg <= wr_data[15:0];
				`OFS_CARRIER:    carrier_freq_setting_reg <= wr_data[10:0];
				default:         ;
			endcase
		end
	end

	// register reads, data valid the cycle after the strobe only
	wire logic [31:0] rd_mux =
		(addr == `OFS_CTRL)       ? {26'h0, ctrl_reg} :
		(addr == `OFS_UPPER)      ? {16'h0, freq_upper_limit_reg} :
		(addr == `OFS_LOWER)      ? {16'h0, freq_lower_limit_reg} :
		(addr == `OFS_GAIN)       ? {16'h0, analog_freq_gain_reg} :
		(addr == `OFS_BIAS)       ? {16'h0, bias_frequency_reg} :
		(addr == `OFS_MAXFREQ)    ? {16'h0, max_freq_reg} :
		(addr == `OFS_DCB_FREQ)   ? {16'h0, dc_brake_start_freq_reg} :
		(addr == `OFS_DCB_LEVEL)  ? {25'h0, dc_brake_level_reg} :
		(addr == `OFS_DCB_TIME)   ? {23'h0, dc_brake_time_reg} :
		(addr == `OFS_START_FREQ) ? {16'h0, starting_freq_reg} :
		(addr == `OFS_HOLD_TIME)  ? {25'h0, starting_hold_time_reg} :
		(addr == `OFS_STOP_FREQ)  ? {16'h0, stopping_freq_reg} :
		(addr == `OFS_CARRIER)    ? {21'h0, carrier_freq_setting_reg} :
		(addr == `OFS_STATUS)     ? {22'h0, refused_reg, dir_reg,
			trip_reg, uv_s, state_reg} :
		(addr == `OFS_OUT_FREQ)   ? {16'h0, out_freq_reg} : 32'h0000_0000;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rd_data_reg <= 32'h0000_0000;
		else
			rd_data_reg <= rd_strobe ? rd_mux : 32'h0000_0000;
	end

	// outputs
	assign rd_data           = rd_data_reg;
	assign drive_out.freq    = out_freq_reg;
	assign drive_out.enable  = (state_reg == drive_frequency_sequencer_pkg::ST_HOLD)
		|| (state_reg == drive_frequency_sequencer_pkg::ST_RUN);
	assign drive_out.reverse = dir_reg;
	assign brake_out.active  = (state_reg == drive_frequency_sequencer_pkg::ST_BRAKE);
	assign brake_out.level   = brake_out.active ? brake_level : 7'h00;
	assign trip              = trip_reg;
	assign carrier_freq = (carrier_freq_setting_reg < `CARRIER_MIN) ? `CARRIER_MIN
		: (carrier_freq_setting_reg > `CARRIER_MAX) ? `CARRIER_MAX
		: carrier_freq_setting_reg;
	assign tone_pattern = (carrier_freq <= `TONE_CARRIER)
		? ctrl_reg.sound_tone_select : 2'h0;
	assign monitor_analog_output = !ctrl_reg.monitor_output_select;
	assign monitor_pulse_output  = ctrl_reg.monitor_output_select;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_loss;
		running && uv_s && rmode != 2'h0;
	endsequence
	sequence s_recover(logic [1:0] m);
		(state_reg == drive_frequency_sequencer_pkg::ST_PWRLOSS) && !uv_s
			&& rmode == m && run_cmd && !pickup_ok;
	endsequence

	a_uv_trip_now: assert property (running && uv_s && rmode == 2'h0 |=>
		trip_reg && !drive_out.enable)
		else $error("mode 0 undervoltage did not trip");
	a_loss_no_trip: assert property (s_loss |=> !trip_reg
		&& (state_reg == drive_frequency_sequencer_pkg::ST_PWRLOSS))
		else $error("power loss tripped or kept running");
	a_mode1_trip: assert property (s_recover(2'h1) |=> trip_reg)
		else $error("mode 1 recovery did not trip");
	a_resume_latch: assert property (s_recover(2'h2) |=>
		out_freq_reg == $past(latched_freq_reg))
		else $error("mode 2 did not resume at latched frequency");
	a_resume_start: assert property (s_recover(2'h3) |=>
		out_freq_reg == $past(starting_freq_reg))
		else $error("mode 3 did not resume at starting frequency");
	a_pickup_window: assert property ((state_reg ==
		drive_frequency_sequencer_pkg::ST_PWRLOSS) && !uv_s && rmode != 2'h1
		&& run_cmd && pickup_ok |=> out_freq_reg >= `PICKUP_MIN
		&& out_freq_reg <= `PICKUP_MAX)
		else $error("pickup speed used outside window");
	a_limit_upper: assert property (target <= freq_upper_limit_reg)
		else $error("setpoint above upper limit");
	a_refuse_start: assert property ((state_reg ==
		drive_frequency_sequencer_pkg::ST_IDLE) && start_refused |=>
		(state_reg == drive_frequency_sequencer_pkg::ST_IDLE) ||
		(state_reg == drive_frequency_sequencer_pkg::ST_TRIPPED))
		else $error("started below stop frequency");
	a_brake_floor: assert property (brake_out.active &&
		dc_brake_level_reg != 7'h00 |-> brake_out.level >= (LARGE_MODEL ?
		`DCB_FLOOR : dc_brake_level_reg))
		else $error("braking level below floor");
	a_brake_zero: assert property (dc_brake_time_reg == 9'h000 &&
		!brake_out.active |=> !brake_out.active)
		else $error("DC braking with zero time");
	a_tone_gate: assert property (carrier_freq > `TONE_CARRIER |->
		tone_pattern == 2'h0)
		else $error("tone applied above 7 kHz");

endmodule : drive_frequency_sequencer

`default_nettype wire

// >>> verif/motor_load_model.sv
`timescale 1ns/1ps
`default_nettype none

module motor_load_model
(
	// clock and reset
	input  wire logic                                 mclk,
	input  wire logic                                 rst,
	// inverter output
	input  wire drive_frequency_sequencer_pkg::drive_out_t drive_out,
	// speed detector
	output logic                                      pickup_valid,
	output logic [15:0]                               pickup_freq
);
	logic [15:0] speed_reg;
	logic [15:0] speed_next;

	// rotor follows the drive, coasts at its last speed once released
	assign speed_next = drive_out.enable ? drive_out.freq : speed_reg;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			speed_reg <= 16'h0000;
		else
			speed_reg <= speed_next;
	end

	// result only while coasting, otherwise a value of no meaning
	assign pickup_valid = !drive_out.enable && speed_reg != 16'h0000;
	assign pickup_freq  = pickup_valid ? speed_reg : ~speed_reg;
endmodule : motor_load_model

`default_nettype wire

// >>> verif/tb_drive_frequency_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "drive_frequency_sequencer_defines.svh"

module tb_drive_frequency_sequencer;
	localparam int EN = 0;
	localparam int FR = 1;
	localparam int TR = 2;
	localparam int BR = 3;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wr_data = 32'h00000000;
	logic        wr_strobe = 1'b0;
	logic        rd_strobe = 1'b0;
	logic [31:0] rd_data;
	logic        run_fwd = 1'b0;
	logic        run_rev = 1'b0;
	logic        undervoltage = 1'b0;
	logic [11:0] analog_in = 12'h000;
	logic        pickup_valid;
	logic [15:0] pickup_freq;
	logic        trip;
	logic [10:0] carrier_freq;
	logic [1:0]  tone_pattern;
	logic        monitor_analog_output;
	logic        monitor_pulse_output;
	int          n_fail = 0;
	int          n_tests = 0;
	drive_frequency_sequencer_pkg::drive_out_t drive_out;
	drive_frequency_sequencer_pkg::brake_out_t brake_out;

	always #5 mclk = ~mclk;

	drive_frequency_sequencer #(.TICK_CYCLES(10), .RAMP_CYCLES(2))
		drive_frequency_sequencer_i (.mclk, .rst, .addr, .wr_data,
		.wr_strobe, .rd_strobe, .rd_data, .run_fwd, .run_rev,
		.undervoltage, .analog_in, .pickup_valid, .pickup_freq,
		.drive_out, .brake_out, .trip, .carrier_freq, .tone_pattern,
		.monitor_analog_output, .monitor_pulse_output);

	motor_load_model motor_load_model_i (.mclk, .rst, .drive_out,
		.pickup_valid, .pickup_freq);

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr      <= a;
		wr_data   <= d;
		wr_strobe <= 1'b1;
		@(posedge mclk);
		wr_strobe <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		@(posedge mclk);
		addr      <= a;
		rd_strobe <= 1'b1;
		@(posedge mclk);
		rd_strobe <= 1'b0;
		@(negedge mclk);
		chk(nm, e, rd_data);
	endtask : rd

	task automatic pins(input logic f, input logic u);
		@(posedge mclk);
		run_fwd      <= f;
		undervoltage <= u;
	endtask : pins

	task automatic pause(input int n);
		repeat (n) @(negedge mclk);
	endtask : pause

	function automatic logic [15:0] probe(input int s);
		case (s)
			EN: return {15'h0000, drive_out.enable};
			FR: return drive_out.freq;
			TR: return {15'h0000, trip};
			default: return {15'h0000, brake_out.active};
		endcase
	endfunction : probe

	task automatic wait_on(input int s, input logic [15:0] v,
		input string nm);
		int i;
		@(negedge mclk);
		for (i = 0; i < 2000 && probe(s) !== v; i++)
			@(negedge mclk);
		chk(nm, {16'h0000, v}, {16'h0000, probe(s)});
	endtask : wait_on

	task automatic t_regs;
		rd(`OFS_UPPER, 32'h00000FA0, "upper");
		rd(`OFS_START_FREQ, 32'h00000005, "start");
		rd(8'h40, 32'h00000000, "unmapped");
		chk("analog", 32'h1, {31'h0, monitor_analog_output});
		wr(`OFS_CTRL, 32'h00000030);
		wr(`OFS_CARRIER, 32'h000002BC);
		pause(3);
		chk("pulse", 32'h1, {31'h0, monitor_pulse_output});
		chk("tone", 32'h2, {30'h0, tone_pattern});
		chk("carrier", 32'h2BC, {21'h0, carrier_freq});
		wr(`OFS_CARRIER, 32'h000002BD);
		pause(3);
		chk("tone off", 32'h0, {30'h0, tone_pattern});
		wr(`OFS_CARRIER, 32'h00000005);
		pause(3);
		chk("carrier min", 32'h4B, {21'h0, carrier_freq});
		wr(`OFS_CARRIER, 32'h00000320);
	endtask : t_regs

	task automatic t_limit;
		wr(`OFS_BIAS, 32'h0000012C);
		wr(`OFS_UPPER, 32'h000000C8);
		wr(`OFS_LOWER, 32'h0000012C);
		pins(1'b1, 1'b0);
		wait_on(EN, 16'h0001, "enable");
		chk("first", 32'h5, {16'h0, drive_out.freq});
		wait_on(FR, 16'h00C8, "limit");
		pause(20);
		chk("held", 32'hC8, {16'h0, drive_out.freq});
	endtask : t_limit

	task automatic t_loss(input logic [31:0] m, input logic [15:0] f);
		wr(`OFS_CTRL, m);
		pins(1'b1, 1'b1);
		wait_on(EN, 16'h0000, "stopped");
		chk("no trip", 32'h0, {31'h0, trip});
		pins(1'b1, 1'b0);
		wait_on(EN, 16'h0001, "resumed");
		chk("resume", {16'h0, f}, {16'h0, drive_out.freq});
		wait_on(FR, 16'h00C8, "target");
	endtask : t_loss

	task automatic t_trip(input logic [31:0] m);
		wr(`OFS_CTRL, m);
		pins(1'b1, 1'b1);
		wait_on(EN, 16'h0000, "stopped");
		pause(20);
		chk("loss trip", {31'h0, m == 32'h0}, {31'h0, trip});
		pins(1'b1, 1'b0);
		wait_on(TR, 16'h0001, "return trip");
		pause(20);
		chk("no restart", 32'h0, {31'h0, drive_out.enable});
		pins(1'b0, 1'b0);
		wr(`OFS_COMMAND, 32'h00000001);
		wait_on(TR, 16'h0000, "cleared");
		pins(1'b1, 1'b0);
		wait_on(FR, 16'h00C8, "target");
	endtask : t_trip

	task automatic t_stop(input logic [31:0] t);
		wr(`OFS_DCB_TIME, t);
		pins(1'b1, 1'b0);
		wait_on(FR, 16'h00C8, "target");
		pins(1'b0, 1'b0);
		wait_on(EN, 16'h0000, "decelerated");
		chk("brake", {31'h0, t != 0}, {31'h0, brake_out.active});
		chk("level", t != 0 ? 32'h3 : 32'h0, {25'h0, brake_out.level});
		pause(9);
		chk("brake held", {31'h0, t != 0}, {31'h0, brake_out.active});
		wait_on(BR, 16'h0000, "brake end");
	endtask : t_stop

	task automatic t_hold;
		wr(`OFS_HOLD_TIME, 32'h00000002);
		pins(1'b1, 1'b0);
		wait_on(EN, 16'h0001, "enable");
		pause(19);
		chk("dwell", 32'h5, {16'h0, drive_out.freq});
	endtask : t_hold

	task automatic t_refuse;
		wr(`OFS_STOP_FREQ, 32'h00000014);
		wr(`OFS_BIAS, 32'h0000000A);
		wr(`OFS_LOWER, 32'h00000000);
		pins(1'b1, 1'b0);
		pause(30);
		chk("refused", 32'h0, {31'h0, drive_out.enable});
		rd(`OFS_STATUS, 32'h00000201, "status");
		pins(1'b0, 1'b0);
	endtask : t_refuse

	task automatic t_gain;
		wr(`OFS_STOP_FREQ, 32'h00000002);
		wr(`OFS_MAXFREQ, 32'h00000064);
		wr(`OFS_BIAS, 32'h000000C8);
		wr(`OFS_UPPER, 32'h000003E8);
		wr(`OFS_GAIN, 32'h00000190);
		@(posedge mclk);
		analog_in <= 12'h800;
		pins(1'b1, 1'b0);
		wait_on(FR, 16'h012C, "gain");
		pause(20);
		chk("gain held", 32'h12C, {16'h0, drive_out.freq});
	endtask : t_gain

	task automatic t_reverse;
		@(posedge mclk);
		run_fwd <= 1'b0;
		run_rev <= 1'b1;
		wait_on(EN, 16'h0000, "reversal stop");
		wait_on(EN, 16'h0001, "reversal start");
		chk("reverse", 32'h1, {31'h0, drive_out.reverse});
		pause(6);
		chk("no dwell", 32'h1, {31'h0, drive_out.freq > 16'h0005});
	endtask : t_reverse

	initial
	begin
		#200000;
		n_fail++;
		end_sim;
	end

	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_regs;
		t_limit;
		t_loss(32'h00000002, 16'h00C8);
		t_loss(32'h00000003, 16'h0005);
		t_loss(32'h00000007, 16'h00C8);
		t_trip(32'h00000001);
		t_trip(32'h00000000);
		wr(`OFS_DCB_FREQ, 32'h00000064);
		wr(`OFS_DCB_LEVEL, 32'h00000003);
		t_stop(32'h00000001);
		t_hold;
		t_stop(32'h00000000);
		t_refuse;
		t_gain;
		t_reverse;
		end_sim;
	end
endmodule : tb_drive_frequency_sequencer

`default_nettype wire
